//--- common/osp_pkg.sv
// Constants, register map and field layout of the pin-option block.
// Assumes a 10 MHz core clock and an AXI4-Lite master with 12-bit addresses.
package osp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus widths and answers
   localparam int unsigned OSP_ADDR_W = 12;
   localparam int unsigned OSP_DATA_W = 32;
   localparam logic [1:0]  OSP_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  OSP_RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Register indexes; byte address is four times the index
   localparam logic [9:0]  OSP_IDX_PIN_OPTION = 10'h09E;
   localparam logic [9:0]  OSP_IDX_IRQ_STATUS = 10'h0A0;
   localparam logic [9:0]  OSP_IDX_IRQ_MASK   = 10'h0A1;
   localparam logic [9:0]  OSP_IDX_MODE       = 10'h0A2;
   localparam logic [11:0] OSP_ADDR_PIN_OPTION = {OSP_IDX_PIN_OPTION, 2'h0};
   localparam logic [11:0] OSP_ADDR_IRQ_STATUS = {OSP_IDX_IRQ_STATUS, 2'h0};
   localparam logic [11:0] OSP_ADDR_IRQ_MASK   = {OSP_IDX_IRQ_MASK, 2'h0};
   localparam logic [11:0] OSP_ADDR_MODE       = {OSP_IDX_MODE, 2'h0};

   ////////////////////////////////////////////////////////////////////////////
   // Pin-option, interrupt and mode field positions
   localparam int unsigned OSP_BIT_PIN_A      = 0;
   localparam int unsigned OSP_BIT_PIN_B      = 1;
   localparam int unsigned OSP_BIT_CLK_OUT_EN = 2;
   localparam int unsigned OSP_BIT_SMBUS      = 3;
   localparam int unsigned OSP_BIT_PAIR_SEL   = 4;
   localparam int unsigned OSP_BIT_GND_A      = 5;
   localparam int unsigned OSP_BIT_GND_B      = 6;
   localparam int unsigned OSP_BIT_HOLD_EN    = 7;
   localparam int unsigned OSP_BIT_IRQ_PUSHBUTTON_INPUT   = 0;
   localparam int unsigned OSP_BIT_MODE_INT   = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and counts
   localparam logic [7:0] OSP_PIN_OPTION_RESET = 8'h00;
   localparam logic       OSP_FUSE_INTERNAL    = 1'h1;
   localparam logic       OSP_MODE_RESET       = 1'h1;
   localparam logic [1:0] OSP_FUSE_CAPTURE_CNT = 2'h3;
   localparam int unsigned OSP_RC_FREQ_MHZ     = 4;
   localparam int unsigned OSP_RC_DIVIDE       = 4;
   localparam int unsigned OSP_MCLK_FREQ_MHZ   = 10;

   ////////////////////////////////////////////////////////////////////////////
   // Pin-option register layout
   typedef struct packed {
      logic i2c_clock_hold_enable;
      logic serial_pair_b_ground_sel;
      logic serial_pair_a_ground_sel;
      logic i2c_pin_pair_select;
      logic smbus_threshold;
      logic rc_clock_out_enable;
      logic xtal_pin_b;
      logic pushbutton_input;
   } osp_pin_option_type;

endpackage : osp_pkg

//--- hw/osp_pin_option.sv
// Oscillator select and pin-option register with an AXI4-Lite slave.
// Assumes fuse and oscillator pin levels arrive asynchronously to mclk_in.
//
// Summary of operation
// - Fuse bit 0 picks crystal mode at 0, internal oscillator at 1.
// - Internal mode runs the on-chip 4 MHz oscillator, no external parts.
// - Internal mode: pin a is pulled-up input, read at bit 0, writes ignored.
// - Internal mode: pin a can raise an interrupt when enabled.
// - Internal mode: pin b driven from bit 1; bit 1 reads latch.
// - Bit 2 set puts core clock mclk_in divided by four on pin b.
// - Bits 0 to 2 control pins only in internal mode.
// - Bit 7 set holds I2C clock low while receive buffer full.
// - Bit 6 selects analog pin 5 or ground for port D pins 1:0.
// - Bit 5 selects analog pin 1 or ground for port C pins 7:6.
// - Bit 4 routes I2C to port D 1:0 at 1, port C 7:6 at 0.
// - Bit 3 picks SMBus thresholds at 1, Schmitt thresholds at 0.
//
// The implementer's own choice: the AXI4-Lite slave port.
module osp_pin_option
   import osp_pkg::*;
(
   // Clock and reset
   input  wire logic                  mclk_in,
   input  wire logic                  rst_n_in,
   // AXI4-Lite write address
   input  wire logic [OSP_ADDR_W-1:0] s_axi_awaddr_in,
   input  wire logic                  s_axi_awvalid_in,
   output logic                       s_axi_awready_out,
   // AXI4-Lite write data
   input  wire logic [OSP_DATA_W-1:0] s_axi_wdata_in,
   input  wire logic [3:0]            s_axi_wstrb_in,
   input  wire logic                  s_axi_wvalid_in,
   output logic                       s_axi_wready_out,
   // AXI4-Lite write response
   output logic [1:0]                 s_axi_bresp_out,
   output logic                       s_axi_bvalid_out,
   input  wire logic                  s_axi_bready_in,
   // AXI4-Lite read
   input  wire logic [OSP_ADDR_W-1:0] s_axi_araddr_in,
   input  wire logic                  s_axi_arvalid_in,
   output logic                       s_axi_arready_out,
   output logic [OSP_DATA_W-1:0]      s_axi_rdata_out,
   output logic [1:0]                 s_axi_rresp_out,
   output logic                       s_axi_rvalid_out,
   input  wire logic                  s_axi_rready_in,
   // Configuration fuse
   input  wire logic                  osc_fuse_in,
   // Oscillator pins
   input  wire logic                  xtal_pin_a_in,
   output logic                       xtal_pin_a_pullup_en_out,
   output logic                       xtal_pin_b_out,
   output logic                       xtal_pin_b_oe_n_out,
   output logic                       internal_osc_en_out,
   // Serial port controls
   input  wire logic                  i2c_rx_full_in,
   output logic                       i2c_clock_hold_out,
   output logic                       serial_pair_b_ground_sel_out,
   output logic                       serial_pair_a_ground_sel_out,
   output logic                       i2c_pin_pair_select_out,
   output logic                       smbus_threshold_out,
   // Interrupt
   output logic                       irq_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic                  aw_held_reg, aw_held_next;
   logic [OSP_ADDR_W-1:0] aw_addr_reg, aw_addr_next;
   logic                  w_held_reg, w_held_next;
   logic [7:0]            w_data_reg, w_data_next;
   logic                  w_lane_reg, w_lane_next;
   logic                  bvalid_reg, bvalid_next;
   logic [1:0]            bresp_reg, bresp_next;
   logic                  rvalid_reg, rvalid_next;
   logic [1:0]            rresp_reg, rresp_next;
   logic [7:0]            rdata_reg, rdata_next;
   logic                  wr_fire;
   logic                  ar_fire;
   logic                  wr_hit;
   logic                  rd_hit;
   logic [7:0]            rd_mux;

   logic                  pin_a_s1_reg, pin_a_s2_reg, pin_a_prev_reg;
   logic                  fuse_s1_reg, fuse_s2_reg;
   logic [1:0]            cap_cnt_reg, cap_cnt_next;
   logic                  mode_int_reg, mode_int_next;
   osp_pin_option_type    opt_reg, opt_next;
   logic                  irq_stat_reg, irq_stat_next;
   logic                  irq_mask_reg, irq_mask_next;
   logic                  irq_reg, irq_next;
   logic [1:0]            div_cnt_reg, div_cnt_next;
   logic                  pin_b_reg, pin_b_next;
   logic                  oe_n_reg, oe_n_next;
   logic                  hold_reg, hold_next;
   logic                  pushbutton_input_event;

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshake
   assign s_axi_awready_out = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready_out  = !w_held_reg && !bvalid_reg;
   assign s_axi_arready_out = !rvalid_reg;
   assign s_axi_bvalid_out  = bvalid_reg;
   assign s_axi_bresp_out   = bresp_reg;
   assign s_axi_rvalid_out  = rvalid_reg;
   assign s_axi_rresp_out   = rresp_reg;
   assign s_axi_rdata_out   = {24'h000000, rdata_reg};

   assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
   assign ar_fire = s_axi_arvalid_in && !rvalid_reg;

   always_comb begin
      wr_hit = (aw_addr_reg == OSP_ADDR_PIN_OPTION) || (aw_addr_reg == OSP_ADDR_IRQ_STATUS)
            || (aw_addr_reg == OSP_ADDR_IRQ_MASK) || (aw_addr_reg == OSP_ADDR_MODE);
      rd_hit = 1'b1;
      rd_mux = 8'h00;
      case (s_axi_araddr_in)
         OSP_ADDR_PIN_OPTION: begin
            rd_mux = opt_reg;
            rd_mux[OSP_BIT_PIN_A] = mode_int_reg && pin_a_s2_reg;
         end
         OSP_ADDR_IRQ_STATUS: rd_mux[OSP_BIT_IRQ_PUSHBUTTON_INPUT] = irq_stat_reg;
         OSP_ADDR_IRQ_MASK:   rd_mux[OSP_BIT_IRQ_PUSHBUTTON_INPUT] = irq_mask_reg;
         OSP_ADDR_MODE:       rd_mux[OSP_BIT_MODE_INT] = mode_int_reg;
         default:             rd_hit = 1'b0;
      endcase
   end

   always_comb begin
      aw_held_next = aw_held_reg;
      aw_addr_next = aw_addr_reg;
      w_held_next  = w_held_reg;
      w_data_next  = w_data_reg;
      w_lane_next  = w_lane_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      rvalid_next  = rvalid_reg;
      rresp_next   = rresp_reg;
      rdata_next   = rdata_reg;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
         aw_held_next = 1'b1;
         aw_addr_next = {s_axi_awaddr_in[OSP_ADDR_W-1:2], 2'h0};
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
         w_held_next = 1'b1;
         w_data_next = s_axi_wdata_in[7:0];
         w_lane_next = s_axi_wstrb_in[0];
      end
      if (wr_fire) begin
         aw_held_next = 1'b0;
         w_held_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = wr_hit ? OSP_RESP_OKAY : OSP_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready_in) begin
         bvalid_next = 1'b0;
      end
      if (ar_fire) begin
         rvalid_next = 1'b1;
         rresp_next  = rd_hit ? OSP_RESP_OKAY : OSP_RESP_SLVERR;
         rdata_next  = rd_mux;
      end else if (rvalid_reg && s_axi_rready_in) begin
         rvalid_next = 1'b0;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
         w_held_reg  <= 1'b0;
         w_data_reg  <= 8'h00;
         w_lane_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= OSP_RESP_OKAY;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= OSP_RESP_OKAY;
         rdata_reg   <= 8'h00;
      end else begin
         aw_held_reg <= aw_held_next;
         aw_addr_reg <= aw_addr_next;
         w_held_reg  <= w_held_next;
         w_data_reg  <= w_data_next;
         w_lane_reg  <= w_lane_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         rvalid_reg  <= rvalid_next;
         rresp_reg   <= rresp_next;
         rdata_reg   <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin and fuse synchronisers
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_a_s1_reg   <= 1'b1;
         pin_a_s2_reg   <= 1'b1;
         pin_a_prev_reg <= 1'b1;
         fuse_s1_reg    <= OSP_FUSE_INTERNAL;
         fuse_s2_reg    <= OSP_FUSE_INTERNAL;
      end else begin
         pin_a_s1_reg   <= xtal_pin_a_in;
         pin_a_s2_reg   <= pin_a_s1_reg;
         pin_a_prev_reg <= pin_a_s2_reg;
         fuse_s1_reg    <= osc_fuse_in;
         fuse_s2_reg    <= fuse_s1_reg;
      end
   end

   // Falling edge of the pulled-up input, internal mode only
   assign pushbutton_input_event = mode_int_reg && pin_a_prev_reg && !pin_a_s2_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Core state
   always_comb begin
      cap_cnt_next  = cap_cnt_reg;
      mode_int_next = mode_int_reg;
      opt_next      = opt_reg;
      irq_stat_next = irq_stat_reg;
      irq_mask_next = irq_mask_reg;
      // Fuse caught once after reset release
      if (cap_cnt_reg != OSP_FUSE_CAPTURE_CNT) begin
         cap_cnt_next = cap_cnt_reg + 2'h1;
         if (cap_cnt_next == OSP_FUSE_CAPTURE_CNT) begin
            mode_int_next = (fuse_s2_reg == OSP_FUSE_INTERNAL);
         end
      end
      if (wr_fire && w_lane_reg) begin
         case (aw_addr_reg)
            OSP_ADDR_PIN_OPTION: begin
               opt_next = w_data_reg;
               opt_next.pushbutton_input = 1'b0;
            end
            OSP_ADDR_IRQ_STATUS: begin
               if (w_data_reg[OSP_BIT_IRQ_PUSHBUTTON_INPUT]) begin
                  irq_stat_next = 1'b0;
               end
            end
            OSP_ADDR_IRQ_MASK: irq_mask_next = w_data_reg[OSP_BIT_IRQ_PUSHBUTTON_INPUT];
            default: ;
         endcase
      end
      // Set wins over a same-cycle clear
      if (pushbutton_input_event) begin
         irq_stat_next = 1'b1;
      end
      irq_next = irq_stat_next && irq_mask_next;
      div_cnt_next = div_cnt_reg + 2'h1;
      hold_next = opt_reg.i2c_clock_hold_enable && i2c_rx_full_in;
      // Pin b owned by the oscillator in crystal mode
      oe_n_next  = !mode_int_reg;
      pin_b_next = 1'b0;
      if (mode_int_reg) begin
         if (opt_reg.rc_clock_out_enable) begin
            pin_b_next = div_cnt_reg[1];
         end else begin
            pin_b_next = opt_reg.xtal_pin_b;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cap_cnt_reg  <= 2'h0;
         mode_int_reg <= OSP_MODE_RESET;
         opt_reg      <= OSP_PIN_OPTION_RESET;
         irq_stat_reg <= 1'b0;
         irq_mask_reg <= 1'b0;
         irq_reg      <= 1'b0;
         div_cnt_reg  <= 2'h0;
         pin_b_reg    <= 1'b0;
         oe_n_reg     <= 1'b1;
         hold_reg     <= 1'b0;
      end else begin
         cap_cnt_reg  <= cap_cnt_next;
         mode_int_reg <= mode_int_next;
         opt_reg      <= opt_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         irq_reg      <= irq_next;
         div_cnt_reg  <= div_cnt_next;
         pin_b_reg    <= pin_b_next;
         oe_n_reg     <= oe_n_next;
         hold_reg     <= hold_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign internal_osc_en_out          = mode_int_reg;
   assign xtal_pin_a_pullup_en_out     = mode_int_reg;
   assign xtal_pin_b_out               = pin_b_reg;
   assign xtal_pin_b_oe_n_out          = oe_n_reg;
   assign i2c_clock_hold_out           = hold_reg;
   assign serial_pair_b_ground_sel_out = opt_reg.serial_pair_b_ground_sel;
   assign serial_pair_a_ground_sel_out = opt_reg.serial_pair_a_ground_sel;
   assign i2c_pin_pair_select_out      = opt_reg.i2c_pin_pair_select;
   assign smbus_threshold_out          = opt_reg.smbus_threshold;
   assign irq_out                      = irq_reg;

endmodule : osp_pin_option

//--- testbench/osp_pin_option_properties.sv
// Port assertions for the pin-option block.
// Bound to the design; single clock, async active-low reset.
module osp_pin_option_properties
   import osp_pkg::*;
(
   // Clock and reset
   input  wire logic mclk_in,
   input  wire logic rst_n_in,
   // Bus
   input  wire logic s_axi_arvalid_in,
   input  wire logic s_axi_arready_out,
   input  wire logic s_axi_bvalid_out,
   input  wire logic s_axi_rvalid_out,
   // Pins and controls
   input  wire logic xtal_pin_a_pullup_en_out,
   input  wire logic xtal_pin_b_out,
   input  wire logic xtal_pin_b_oe_n_out,
   input  wire logic internal_osc_en_out,
   input  wire logic i2c_rx_full_in,
   input  wire logic i2c_clock_hold_out,
   input  wire logic serial_pair_b_ground_sel_out,
   input  wire logic serial_pair_a_ground_sel_out,
   input  wire logic i2c_pin_pair_select_out,
   input  wire logic smbus_threshold_out,
   input  wire logic irq_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_n_in);

   ////////////////////////////////////////////////////////////////////////////
   // Cycles since reset, saturating
   logic [2:0] cnt_reg;
   logic [2:0] cnt_next;
   always_comb begin
      cnt_next = cnt_reg + ((cnt_reg != 3'h7) ? 3'h1 : 3'h0);
   end
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_reg <= 3'h0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence wr_answer_s;
      $rose(s_axi_bvalid_out);
   endsequence
   hold_cause_a: assert property (i2c_clock_hold_out |-> $past(i2c_rx_full_in))
      else $error("clock hold without full buffer");
   irq_mode_a: assert property (irq_out |-> internal_osc_en_out)
      else $error("interrupt outside internal mode");
   crystal_pin_a: assert property (!internal_osc_en_out && !$past(internal_osc_en_out)
      |-> xtal_pin_b_oe_n_out && !xtal_pin_b_out) else $error("pin b driven in crystal mode");
   internal_drive_a: assert property (internal_osc_en_out [*3] |-> !xtal_pin_b_oe_n_out)
      else $error("pin b not driven in internal mode");
   pullup_on_a: assert property (internal_osc_en_out [*2] |-> xtal_pin_a_pullup_en_out)
      else $error("pin a pull-up off in internal mode");
   serial_sel_a: assert property ($changed({serial_pair_b_ground_sel_out,
      serial_pair_a_ground_sel_out, i2c_pin_pair_select_out, smbus_threshold_out})
      |-> wr_answer_s) else $error("serial select changed without write");
   mode_lock_a: assert property (cnt_reg == 3'h7 |-> $stable(internal_osc_en_out))
      else $error("clock source changed after capture");
   read_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read answer late");
endmodule : osp_pin_option_properties

bind osp_pin_option osp_pin_option_properties osp_pin_option_properties_inst (.*);

//--- testbench/osp_xtal_model.sv
// Far-side model: pushbutton on pin a in internal mode, clock in crystal mode.
// Assumes the device pull-up enable and mode outputs are visible.
module osp_xtal_model
   import osp_pkg::*;
(
   // Device side
   input  wire logic internal_osc_en_in,
   input  wire logic pullup_en_in,
   // Bench control
   input  wire logic press_in,
   // Pin a
   output logic      pin_a_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic osc_reg = 1'b0;
   always #37 osc_reg = ~osc_reg;
   always_comb begin
      if (!internal_osc_en_in) begin
         pin_a_out = osc_reg;
      end else if (press_in) begin
         pin_a_out = 1'b0;
      end else if (pullup_en_in) begin
         pin_a_out = 1'b1;
      end else begin
         pin_a_out = osc_reg;
      end
   end
endmodule : osp_xtal_model

//--- testbench/osp_pin_option_test.sv
// Self-checking bench for the pin-option block.
// Drives AXI4-Lite, fuse and I2C status; the crystal model sits on pin a.
module osp_pin_option_test
   import osp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk_in, rst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
   logic        s_axi_arvalid_in, s_axi_rready_in, osc_fuse_in, xtal_pin_a_in, i2c_rx_full_in;
   logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
   logic        s_axi_rvalid_out, xtal_pin_a_pullup_en_out, xtal_pin_b_out, xtal_pin_b_oe_n_out;
   logic        internal_osc_en_out, i2c_clock_hold_out, serial_pair_b_ground_sel_out, irq_out;
   logic        serial_pair_a_ground_sel_out, i2c_pin_pair_select_out, smbus_threshold_out, press;
   logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
   logic [31:0] s_axi_wdata_in, s_axi_rdata_out, d;
   logic [3:0]  s_axi_wstrb_in;
   logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, r;
   logic [7:0]  v;
   int          err_count, compares, n;
   logic        b;

   osp_pin_option osp_pin_option_inst (.*);
   osp_xtal_model osp_xtal_model_inst (.internal_osc_en_in(internal_osc_en_out),
      .pullup_en_in(xtal_pin_a_pullup_en_out), .press_in(press), .pin_a_out(xtal_pin_a_in));

   always #50 mclk_in = ~mclk_in;

   ////////////////////////////////////////////////////////////////////////////
   // Tasks
   task automatic conclude();
      $display("Mismatches %0d, compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tmo();
      err_count++;
      $display("[FAIL] %0t bus timeout", $time);
      conclude();
   endtask : tmo
   task automatic wr(input logic [11:0] a, input logic [31:0] dw, output logic [1:0] rw);
      logic ha, hw, hb;
      int k;
      k = 0;
      hb = 1'b0;
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= dw;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      while (!hb && k < 40) begin
         @(negedge mclk_in);
         ha = s_axi_awvalid_in && s_axi_awready_out;
         hw = s_axi_wvalid_in && s_axi_wready_out;
         hb = s_axi_bvalid_out;
         rw = s_axi_bresp_out;
         @(posedge mclk_in);
         if (ha) s_axi_awvalid_in <= 1'b0;
         if (hw) s_axi_wvalid_in <= 1'b0;
         k++;
      end
      if (!hb) tmo();
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] dr, output logic [1:0] rr);
      logic ha, hr;
      int k;
      k = 0;
      hr = 1'b0;
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      while (!hr && k < 40) begin
         @(negedge mclk_in);
         ha = s_axi_arvalid_in && s_axi_arready_out;
         hr = s_axi_rvalid_out;
         dr = s_axi_rdata_out;
         rr = s_axi_rresp_out;
         @(posedge mclk_in);
         if (ha) s_axi_arvalid_in <= 1'b0;
         k++;
      end
      if (!hr) tmo();
   endtask : rd
   task automatic wait_neg(input int k);
      repeat (k) @(posedge mclk_in);
      @(negedge mclk_in);
   endtask : wait_neg
   task automatic do_reset(input logic fuse);
      osc_fuse_in <= fuse;
      rst_n_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      repeat (6) @(posedge mclk_in);
   endtask : do_reset
   function automatic logic [31:0] opt_exp(input logic [7:0] val, input logic pin);
      return {24'h0, val[7:1], pin};
   endfunction : opt_exp

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {mclk_in, rst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_arvalid_in} = 5'h0;
      {i2c_rx_full_in, press, s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
      {s_axi_bready_in, s_axi_rready_in, osc_fuse_in, s_axi_wstrb_in} = 7'h7F;
      err_count = 0;
      compares = 0;
      void'($urandom(32'hD33A9E41));
      do_reset(1'b1);
      rd(OSP_ADDR_PIN_OPTION, d, r);
      chk(d, opt_exp(8'h00, 1'b1));
      rd(OSP_ADDR_MODE, d, r);
      chk(d, 32'h1);
      chk({30'h0, internal_osc_en_out, xtal_pin_a_pullup_en_out}, 32'h3);
      for (int i = 0; i < 8; i++) begin
         v = (i == 0) ? 8'hFF : (i == 1) ? 8'h01 : 8'($urandom);
         wr(OSP_ADDR_PIN_OPTION, {24'($urandom), v}, r);
         rd(OSP_ADDR_PIN_OPTION, d, r);
         chk(d, opt_exp(v, 1'b1));
         i2c_rx_full_in <= 1'b1;
         wait_neg(2);
         chk({31'h0, i2c_clock_hold_out}, {31'h0, v[7]});
         chk({28'h0, serial_pair_b_ground_sel_out, serial_pair_a_ground_sel_out,
            i2c_pin_pair_select_out, smbus_threshold_out}, {28'h0, v[6:3]});
         chk({31'h0, xtal_pin_b_oe_n_out}, 32'h0);
         b = xtal_pin_b_out;
         n = 0;
         repeat (8) begin
            @(negedge mclk_in);
            n += int'(xtal_pin_b_out !== b);
            b = xtal_pin_b_out;
         end
         if (v[2]) chk(n, 4);
         else chk({31'h0, b}, {31'h0, v[1]});
         @(posedge mclk_in);
         i2c_rx_full_in <= 1'b0;
      end
      for (int m = 1; m >= 0; m--) begin
         wr(OSP_ADDR_IRQ_MASK, 32'(m), r);
         press <= 1'b1;
         wait_neg(8);
         chk({31'h0, irq_out}, 32'(m));
         @(posedge mclk_in);
         rd(OSP_ADDR_PIN_OPTION, d, r);
         chk({31'h0, d[0]}, 32'h0);
         press <= 1'b0;
         rd(OSP_ADDR_IRQ_STATUS, d, r);
         chk(d, 32'h1);
         wr(OSP_ADDR_IRQ_STATUS, 32'h1, r);
         wait_neg(3);
         chk({31'h0, irq_out}, 32'h0);
         @(posedge mclk_in);
      end
      rd(12'hFFC, d, r);
      chk({r, d[29:0]}, {OSP_RESP_SLVERR, 30'h0});
      wr(12'hFFC, 32'hFF, r);
      chk({30'h0, r}, {30'h0, OSP_RESP_SLVERR});
      wr(OSP_ADDR_MODE, 32'h0, r);
      rd(OSP_ADDR_MODE, d, r);
      chk(d, 32'h1);
      do_reset(1'b0);
      rd(OSP_ADDR_MODE, d, r);
      chk(d, 32'h0);
      chk({30'h0, internal_osc_en_out, xtal_pin_a_pullup_en_out}, 32'h0);
      v = 8'($urandom) | 8'h07;
      wr(OSP_ADDR_PIN_OPTION, {24'h0, v}, r);
      rd(OSP_ADDR_PIN_OPTION, d, r);
      chk(d, opt_exp(v, 1'b0));
      s_axi_wstrb_in <= 4'hE;
      wr(OSP_ADDR_PIN_OPTION, 32'h0, r);
      chk({30'h0, r}, {30'h0, OSP_RESP_OKAY});
      s_axi_wstrb_in <= 4'hF;
      rd(OSP_ADDR_PIN_OPTION, d, r);
      chk(d, opt_exp(v, 1'b0));
      wait_neg(1);
      chk({30'h0, xtal_pin_b_oe_n_out, xtal_pin_b_out}, 32'h2);
      conclude();
   end
endmodule : osp_pin_option_test
